/* File: design/dgde_pkg.sv */
/*
  constants and types shared by the dynamics processor (gate, ducker, expander).
  assumes level figures in dB, attenuation kept in half-dB steps, hold and decay times in samples, attack in ms.
*/
package dgde_pkg;
  // -------------------------------------------------------------
  // widths and buffer
  // -------------------------------------------------------------
  localparam int DW = 24;
  localparam int FIFO_D = 8;
  localparam int HOLD_W = 17;
  localparam int DECAY_W = 21;
  // -------------------------------------------------------------
  // algorithm select codes
  // -------------------------------------------------------------
  localparam logic [2:0] MD_GATE = 3'h0;
  localparam logic [2:0] MD_DUCK = 3'h1;
  localparam logic [2:0] MD_EXP = 3'h2;
  localparam logic [2:0] MD_COMP = 3'h3;
  localparam logic [2:0] MD_CMPH = 3'h4;
  localparam logic [2:0] MD_CMPS = 3'h5;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_ACT = 3'h2, ST_HOLD = 3'h4} dgde_st_e;
  // -------------------------------------------------------------
  // parameter ranges and scaling
  // -------------------------------------------------------------
  localparam int THR_STEPS = 55;
  localparam int THR_MIN_DB = -54;
  localparam int RANGE_MAX_DB = 70;
  localparam int MAKEUP_MAX_HDB = 36;
  localparam int ATT_MAX_MS = 120;
  localparam int KNEE_MAX = 5;
  localparam int KNEE_DB_PER_STEP = 2;
  localparam int RATIO_INF = 15;
  localparam int RATIO_UNIT = 10;
  localparam int MUTE_HDB = 140;
  localparam int ENV_STEPS = 140;
  localparam int FS_48K_HZ = 48000;
  localparam int FS_44K_HZ = 44100;
  localparam int MS_PER_S = 1000;
  localparam int DB_PER_BIT = 6;
  localparam int LVL_FLOOR_DB = -127;
  localparam int HDB_PER_OCT = 12;
  localparam int Q_SHIFT = 12;
  localparam logic [15:0] GAIN_Q15 [12] = '{16'h8000, 16'h78D7, 16'h7215, 16'h6BB3, 16'h65AD, 16'h5FFD,
    16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};
  localparam logic [7:0] RATIO_X10 [16] = '{8'h0A, 8'h0B, 8'h0D, 8'h0F, 8'h11, 8'h14, 8'h19, 8'h1E,
    8'h23, 8'h28, 8'h32, 8'h3C, 8'h50, 8'h64, 8'hC8, 8'hFF};
  localparam logic [2:0] FRAC_DB [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
endpackage

/* File: design/dgde_top.sv */
/*
  sample fifo and per-channel gate / ducker / expander with hold and envelope timing.
  assumes samples, key and settings come from logic on the same clock; one sample per take.
*/
`timescale 1ns/1ps
// Function
// - gate passes audio above threshold, closes at or below; threshold -54..0 dB (thr_step is not limited, so up to +9 dB)
// - gate range sets closed floor -70..0 dB; 0 dB does nothing
// - range -70 dB mutes fully below threshold
// - gate stays open for hold samples after trigger falls
// - gate attack sets rise speed to unity, 0..120 ms
// - gate decay sets fall speed to floor after hold
// - trigger level comes from own channel or selected key channel
// - ducker acts at or above threshold, idle below
// - ducker attenuates by range magnitude
// - ducking stays active for hold samples
// - ducker attack sets how fast attenuation applies
// - ducker decay sets return speed to normal gain
// - expander passes above threshold, attenuates at or below
// - sixteen ratios; output change is ratio times input change
// - infinite ratio mutes like a gate
// - expander makeup gain 0..18 dB in half-dB steps
// - hard knee full ratio at once; knee 1..5 gradual
// - expander attack sets onset speed
// - expander release sets return speed above threshold
// - one algorithm per channel; compressor types pass unchanged here

module dgde_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  generate
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two");
    end
  endgenerate
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt, wr, rd;
  always_comb begin
    wr = ce && in_valid && !full_r;
    rd = ce && out_ready && (cnt_r != '0);
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    full_nxt = (cnt_nxt == (AW+1)'(D));
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
    end
  end
  always_ff @(posedge clock) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
  end
  assign in_ready = !full_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
endmodule

module dgde_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [dgde_pkg::DW-1:0] in_audio,
  input wire logic [dgde_pkg::DW-1:0] in_key,
  output logic in_ready,
  output logic out_valid,
  output logic [dgde_pkg::DW-1:0] out_audio,
  input wire logic out_ready,
  input wire logic [2:0] mode,
  input wire logic key_sel,
  input wire logic fs_sel,
  input wire logic [5:0] thr_step,
  input wire logic [6:0] range_db,
  input wire logic [5:0] makeup_hdb,
  input wire logic [3:0] ratio_sel,
  input wire logic [2:0] knee_sel,
  input wire logic [6:0] attack_ms,
  input wire logic [dgde_pkg::HOLD_W-1:0] hold_smp,
  input wire logic [dgde_pkg::DECAY_W-1:0] decay_smp,
  output logic active,
  output logic [7:0] att_hdb
);
  localparam int DW = dgde_pkg::DW;
  localparam longint SMAX = (longint'(1) <<< (DW - 1)) - 1;
  localparam longint SMIN = -(longint'(1) <<< (DW - 1));

  logic f_valid, f_rd, take, fifo_rdy;
  logic [2*DW-1:0] f_data;
  logic signed [DW-1:0] f_aud, key;
  logic [DW-1:0] mag, norm;
  int pos, lvl, thr, d, w, de2, exp_att, tgt, up_t, dn_t, per, a_ms, atk, g, lin, rng2, mk;
  longint prod;
  logic act, hold_ok, engaged;
  dgde_pkg::dgde_st_e st_r, st_nxt;
  logic [dgde_pkg::HOLD_W-1:0] hc_r, hc_nxt;
  logic [7:0] cur_r, cur_nxt;
  logic [14:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt, act_r, act_nxt, rdy_r;
  logic [DW-1:0] od_r, od_nxt;

  // -------------------------------------------------------------
  // sample buffer
  // -------------------------------------------------------------
  dgde_fifo #(.W(2 * DW), .D(dgde_pkg::FIFO_D)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(in_valid && rdy_r),
    .in_data({in_key, in_audio}),
    .in_ready(fifo_rdy),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_rd)
  );
  assign take = ce && f_valid && (!ov_r || out_ready);
  assign f_rd = take;
  assign f_aud = f_data[DW-1:0];

  // -------------------------------------------------------------
  // trigger level detector
  // -------------------------------------------------------------
  always_comb begin
    key = key_sel ? f_data[2*DW-1:DW] : f_aud;
    mag = key[DW-1] ? -key : key;
    pos = 0;
    for (int i = 0; i < DW; i++) begin
      if (mag[i]) begin
        pos = i;
      end
    end
    norm = mag << (DW - 1 - pos);
    lvl = (mag == '0) ? dgde_pkg::LVL_FLOOR_DB :
      dgde_pkg::DB_PER_BIT * (pos - (DW - 1)) + int'(dgde_pkg::FRAC_DB[norm[DW-2 -: 2]]);
    thr = int'(thr_step) + dgde_pkg::THR_MIN_DB;
    case (mode)
      dgde_pkg::MD_GATE: act = (lvl > thr);
      dgde_pkg::MD_DUCK: act = (lvl >= thr);
      dgde_pkg::MD_EXP: act = (lvl <= thr);
      default: act = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // trigger state and hold
  // -------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    hc_nxt = hc_r;
    hold_ok = (mode == dgde_pkg::MD_GATE || mode == dgde_pkg::MD_DUCK) && (hold_smp != '0);
    if (take) begin
      case (st_r)
        dgde_pkg::ST_IDLE: begin
          if (act) begin
            st_nxt = dgde_pkg::ST_ACT;
          end
        end
        dgde_pkg::ST_ACT: begin
          if (!act && hold_ok) begin
            st_nxt = dgde_pkg::ST_HOLD;
            hc_nxt = hold_smp;
          end else if (!act) begin
            st_nxt = dgde_pkg::ST_IDLE;
          end
        end
        dgde_pkg::ST_HOLD: begin
          if (act) begin
            st_nxt = dgde_pkg::ST_ACT;
          end else if (hc_r <= 1) begin
            st_nxt = dgde_pkg::ST_IDLE;
          end else begin
            hc_nxt = hc_r - 1'b1;
          end
        end
        default: st_nxt = dgde_pkg::ST_IDLE;
      endcase
    end
    engaged = (st_nxt != dgde_pkg::ST_IDLE);
    act_nxt = take ? engaged : act_r;
  end

  // -------------------------------------------------------------
  // target attenuation and envelope timing
  // -------------------------------------------------------------
  always_comb begin
    rng2 = 2 * ((int'(range_db) > dgde_pkg::RANGE_MAX_DB) ? dgde_pkg::RANGE_MAX_DB : int'(range_db));
    d = thr - lvl;
    w = dgde_pkg::KNEE_DB_PER_STEP * ((int'(knee_sel) > dgde_pkg::KNEE_MAX) ? dgde_pkg::KNEE_MAX : int'(knee_sel));
    if (w == 0) begin
      de2 = 2 * d;
    end else if (d >= 2 * w) begin
      de2 = 2 * (d - w);
    end else begin
      de2 = (d * d) / (2 * w);
    end
    if (int'(ratio_sel) == dgde_pkg::RATIO_INF) begin
      exp_att = dgde_pkg::MUTE_HDB;
    end else begin
      exp_att = (int'(dgde_pkg::RATIO_X10[ratio_sel]) - dgde_pkg::RATIO_UNIT) * de2 / dgde_pkg::RATIO_UNIT;
    end
    if (exp_att > dgde_pkg::MUTE_HDB) begin
      exp_att = dgde_pkg::MUTE_HDB;
    end
    case (mode)
      dgde_pkg::MD_GATE: tgt = engaged ? 0 : rng2;
      dgde_pkg::MD_DUCK: tgt = engaged ? rng2 : 0;
      dgde_pkg::MD_EXP: tgt = act ? exp_att : 0;
      default: tgt = 0;
    endcase
    a_ms = (int'(attack_ms) > dgde_pkg::ATT_MAX_MS) ? dgde_pkg::ATT_MAX_MS : int'(attack_ms);
    atk = a_ms * (fs_sel ? dgde_pkg::FS_44K_HZ : dgde_pkg::FS_48K_HZ) / dgde_pkg::MS_PER_S;
    // gate rises with attack; ducker and expander attenuate with attack
    up_t = (mode == dgde_pkg::MD_GATE) ? int'(decay_smp) : atk;
    dn_t = (mode == dgde_pkg::MD_GATE) ? atk : int'(decay_smp);
    per = ((int'(cur_r) < tgt) ? up_t : dn_t) / dgde_pkg::ENV_STEPS;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r;
    if (take) begin
      if (int'(cur_r) == tgt) begin
        cnt_nxt = '0;
      end else if (per == 0) begin
        cnt_nxt = '0;
        cur_nxt = 8'(tgt);
      end else if (int'(cnt_r) + 1 >= per) begin
        cnt_nxt = '0;
        cur_nxt = (int'(cur_r) < tgt) ? cur_r + 8'h01 : cur_r - 8'h01;
      end else begin
        cnt_nxt = cnt_r + 15'h0001;
      end
    end
  end

  // -------------------------------------------------------------
  // gain stage and output register
  // -------------------------------------------------------------
  always_comb begin
    mk = (mode == dgde_pkg::MD_EXP) ? ((int'(makeup_hdb) > dgde_pkg::MAKEUP_MAX_HDB) ?
      dgde_pkg::MAKEUP_MAX_HDB : int'(makeup_hdb)) : 0;
    g = int'(cur_r) + dgde_pkg::MAKEUP_MAX_HDB - mk;
    lin = int'(dgde_pkg::GAIN_Q15[g % dgde_pkg::HDB_PER_OCT]) >> (g / dgde_pkg::HDB_PER_OCT);
    prod = (longint'(f_aud) * longint'(lin)) >>> dgde_pkg::Q_SHIFT;
    if (prod > SMAX) begin
      prod = SMAX;
    end else if (prod < SMIN) begin
      prod = SMIN;
    end
    od_nxt = od_r;
    ov_nxt = ov_r;
    if (take) begin
      ov_nxt = 1'b1;
      od_nxt = (int'(cur_r) >= dgde_pkg::MUTE_HDB) ? '0 : prod[DW-1:0];
    end else if (ce && out_ready) begin
      ov_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= dgde_pkg::ST_IDLE;
      hc_r <= '0;
      cur_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
      act_r <= 1'b0;
      rdy_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      hc_r <= hc_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
      act_r <= act_nxt;
      rdy_r <= fifo_rdy;
    end
  end
  assign in_ready = rdy_r && fifo_rdy;
  assign out_valid = ov_r;
  assign out_audio = od_r;
  assign active = act_r;
  assign att_hdb = cur_r;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take_flat;
    take && cur_r == 8'h00 && mk == 0;
  endsequence
  sequence s_hold_enter;
    take && st_r == dgde_pkg::ST_ACT && st_nxt == dgde_pkg::ST_HOLD;
  endsequence
  a_unity_pass: assert property (s_take_flat |=> out_audio == $past(f_aud))
    else $error("unity gain did not pass sample");
  a_full_mute: assert property (take && cur_r >= 8'h8C |=> out_audio == '0)
    else $error("mute level did not silence output");
  a_hold_load: assert property (s_hold_enter |=> st_r == dgde_pkg::ST_HOLD && hc_r == $past(hold_smp))
    else $error("hold count not loaded");
  a_hold_open: assert property (st_r == dgde_pkg::ST_HOLD && engaged && mode == dgde_pkg::MD_GATE |-> tgt == 0)
    else $error("gate closing during hold");
  a_gate_floor: assert property (take && mode == dgde_pkg::MD_GATE && !engaged |-> tgt == rng2)
    else $error("closed gate floor wrong");
  a_duck_depth: assert property (take && mode == dgde_pkg::MD_DUCK && lvl >= thr |-> tgt == rng2)
    else $error("duck depth wrong");
  a_exp_above: assert property (take && mode == dgde_pkg::MD_EXP && lvl > thr |-> tgt == 0)
    else $error("expander acted above threshold");
  a_env_step: assert property (take && per != 0 |=> (cur_r - $past(cur_r) <= 8'h01) ||
    ($past(cur_r) - cur_r <= 8'h01))
    else $error("envelope moved more than one step");
  a_comp_idle: assert property (take && mode > dgde_pkg::MD_EXP |-> tgt == 0)
    else $error("unsupported algorithm attenuated");
endmodule

/* File: verif/dgde_sink.sv */
/*
  sink model of the mixer bus that takes processed samples.
  assumes the clock and reset of the block; stall holds ready low.
*/
`timescale 1ns/1ps
module dgde_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [23:0] out_audio,
  output logic out_ready
);
  logic [23:0] got [$];
  logic [23:0] last;
  // ready moves only just after an edge; a word is taken where both are high
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        got.push_back(out_audio);
        last <= out_audio;
      end
    end
  end
endmodule

/* File: verif/dgde_top_test.sv */
/*
  self-checking bench for the gate / ducker / expander.
  assumes the sink model above; settings are plain ports driven here.
*/
`timescale 1ns/1ps
module dgde_top_test;
  localparam logic [23:0] LOUD = 24'h400000;
  localparam logic [23:0] Q1 = 24'h000800;
  localparam logic [23:0] Q2 = 24'h000400;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic in_valid = 1'b0;
  logic [23:0] in_audio = 24'h000000;
  logic [23:0] in_key = 24'h000000;
  logic in_ready, out_valid, out_ready, active, stall = 1'b0;
  logic [23:0] out_audio;
  logic [2:0] mode = 3'h0;
  logic key_sel = 1'b0;
  logic fs_sel = 1'b0;
  logic [5:0] thr_step = 6'h1E;
  logic [6:0] range_db = 7'h00;
  logic [5:0] makeup_hdb = 6'h00;
  logic [3:0] ratio_sel = 4'h0;
  logic [2:0] knee_sel = 3'h0;
  logic [6:0] attack_ms = 7'h00;
  logic [16:0] hold_smp = 17'h00000;
  logic [20:0] decay_smp = 21'h000000;
  logic [7:0] att_hdb, a1, a2;
  int err_total = 0;
  int samples_checked = 0;
  always #25 clock = ~clock;
  dgde_top dut (.clock(clock), .rst_n(rst_n), .ce(ce), .in_valid(in_valid), .in_audio(in_audio),
    .in_key(in_key), .in_ready(in_ready), .out_valid(out_valid), .out_audio(out_audio),
    .out_ready(out_ready), .mode(mode), .key_sel(key_sel), .fs_sel(fs_sel), .thr_step(thr_step),
    .range_db(range_db), .makeup_hdb(makeup_hdb), .ratio_sel(ratio_sel), .knee_sel(knee_sel),
    .attack_ms(attack_ms), .hold_smp(hold_smp), .decay_smp(decay_smp), .active(active), .att_hdb(att_hdb));
  dgde_sink u_sink (.clock(clock), .rst_n(rst_n), .stall(stall), .out_valid(out_valid),
    .out_audio(out_audio), .out_ready(out_ready));
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic setup(input logic [2:0] md, input logic [6:0] rng, input logic [16:0] hd);
    @(posedge clock);
    mode <= md;
    range_db <= rng;
    hold_smp <= hd;
  endtask
  // n samples in, one at a time; wait until the sink has each
  task automatic run(input logic [23:0] a, input logic [23:0] k, input int n);
    int c, w;
    for (int i = 0; i < n; i++) begin
      c = u_sink.got.size();
      @(posedge clock);
      in_audio <= a;
      in_key <= k;
      in_valid <= 1'b1;
      @(posedge clock);
      while (in_ready !== 1'b1) @(posedge clock);
      in_valid <= 1'b0;
      w = 0;
      while (u_sink.got.size() == c && w < 50) begin
        @(posedge clock);
        w++;
      end
      chk(w < 50, 1'b1);
      @(posedge clock);
    end
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_gate;
    setup(dgde_pkg::MD_GATE, 7'h46, 17'h0);
    run(LOUD, 24'h0, 3);
    chk(u_sink.last, LOUD);
    run(Q1, 24'h0, 4);
    chk(att_hdb, 8'h8C);
    chk(u_sink.last, 24'h0);
    chk(active, 1'b0);
    setup(dgde_pkg::MD_GATE, 7'h1E, 17'h0);
    run(Q1, 24'h0, 3);
    chk(att_hdb, 8'h3C);
    setup(dgde_pkg::MD_GATE, 7'h00, 17'h0);
    run(Q1, 24'h0, 3);
    chk(u_sink.last, Q1);
    setup(dgde_pkg::MD_GATE, 7'h46, 17'h0);
    key_sel <= 1'b1;
    run(LOUD, Q1, 4);
    chk(att_hdb, 8'h8C);
    run(Q1, LOUD, 4);
    chk(u_sink.last, Q1);
    key_sel <= 1'b0;
    $display("test gate done");
  endtask
  task automatic t_duck;
    setup(dgde_pkg::MD_DUCK, 7'h1E, 17'h0);
    key_sel <= 1'b1;
    run(Q1, LOUD, 3);
    chk(active, 1'b1);
    chk(att_hdb, 8'h3C);
    run(LOUD, Q1, 4);
    chk(att_hdb, 8'h00);
    chk(u_sink.last, LOUD);
    key_sel <= 1'b0;
    $display("test duck done");
  endtask
  task automatic t_hold;
    for (int m = 0; m < 2; m++) begin
      setup(m ? dgde_pkg::MD_DUCK : dgde_pkg::MD_GATE, 7'h0A, 17'h6);
      run(LOUD, 24'h0, 2);
      run(Q1, 24'h0, 2);
      chk(active, 1'b1);
      chk(att_hdb, m ? 8'h14 : 8'h00);
      run(Q1, 24'h0, 12);
      chk(active, 1'b0);
      chk(att_hdb, m ? 8'h00 : 8'h14);
    end
    $display("test hold done");
  endtask
  task automatic t_env;
    setup(dgde_pkg::MD_GATE, 7'h0A, 17'h0);
    decay_smp <= 21'd280;
    run(LOUD, 24'h0, 3);
    run(Q1, 24'h0, 6);
    chk(att_hdb > 8'h00 && att_hdb < 8'h14, 1'b1);
    run(Q1, 24'h0, 60);
    chk(att_hdb, 8'h14);
    attack_ms <= 7'd10;
    fs_sel <= 1'b1;
    run(LOUD, 24'h0, 3);
    chk(att_hdb > 8'h00 && att_hdb < 8'h14, 1'b1);
    run(LOUD, 24'h0, 80);
    chk(att_hdb, 8'h00);
    attack_ms <= 7'd0;
    decay_smp <= 21'd0;
    $display("test envelope done");
  endtask
  task automatic t_exp;
    setup(dgde_pkg::MD_EXP, 7'h0, 17'h0);
    thr_step <= 6'h00;
    for (int r = 1; r < 3; r++) begin
      ratio_sel <= r == 1 ? 4'h5 : 4'h7;
      run(Q1, 24'h0, 2);
      a1 = att_hdb;
      run(Q2, 24'h0, 2);
      chk(att_hdb - a1, 8'(12 * r));
    end
    ratio_sel <= 4'h5;
    knee_sel <= 3'h1;
    run(Q2, 24'h0, 2);
    a2 = att_hdb;
    knee_sel <= 3'h0;
    run(Q2, 24'h0, 2);
    chk(att_hdb - a2, 8'h04);
    ratio_sel <= 4'h0;
    run(Q2, 24'h0, 2);
    chk(att_hdb, 8'h00);
    ratio_sel <= 4'hF;
    run(Q2, 24'h0, 3);
    chk(u_sink.last, 24'h0);
    run(LOUD, 24'h0, 3);
    chk(u_sink.last, LOUD);
    makeup_hdb <= 6'd12;
    run(24'h100000, 24'h0, 2);
    chk(u_sink.last > 24'h1F0000 && u_sink.last < 24'h210000, 1'b1);
    makeup_hdb <= 6'd0;
    attack_ms <= 7'd10;
    decay_smp <= 21'd280;
    run(Q2, 24'h0, 4);
    chk(att_hdb, 8'h01);
    run(LOUD, 24'h0, 1);
    chk(att_hdb, 8'h00);
    attack_ms <= 7'd0;
    decay_smp <= 21'd0;
    thr_step <= 6'h1E;
    $display("test expander done");
  endtask
  task automatic t_fifo;
    int n0, tk;
    setup(dgde_pkg::MD_COMP, 7'h46, 17'h0);
    n0 = u_sink.got.size();
    tk = 0;
    stall <= 1'b1;
    @(posedge clock);
    in_valid <= 1'b1;
    in_audio <= 24'h000100;
    repeat (30) begin
      @(posedge clock);
      if (in_ready === 1'b1) begin
        tk++;
        in_audio <= 24'h000100 + 24'(tk);
      end
    end
    in_valid <= 1'b0;
    chk(in_ready, 1'b0);
    chk(tk, dgde_pkg::FIFO_D + 1);
    stall <= 1'b0;
    repeat (40) @(posedge clock);
    chk(u_sink.got.size() - n0, tk);
    chk(out_valid, 1'b0);
    for (int i = 0; i < tk; i++) chk(u_sink.got[n0 + i], 24'h000100 + 24'(i));
    for (int m = 4; m < 6; m++) begin
      setup(3'(m), 7'h46, 17'h0);
      run(Q1, 24'h0, 2);
      chk(u_sink.last, Q1);
    end
    $display("test fifo done");
  endtask
  // enable low freezes everything, then a reset in mid-run
  task automatic t_ce;
    int n0;
    setup(dgde_pkg::MD_GATE, 7'h46, 17'h0);
    run(LOUD, 24'h0, 2);
    n0 = u_sink.got.size();
    ce <= 1'b0;
    in_audio <= Q1;
    in_valid <= 1'b1;
    repeat (6) @(posedge clock);
    ce <= 1'b1;
    in_valid <= 1'b0;
    repeat (4) @(posedge clock);
    chk(u_sink.got.size() - n0, 24'h0);
    chk(att_hdb, 8'h00);
    chk(active, 1'b1);
    chk(out_valid, 1'b0);
    run(Q1, 24'h0, 2);
    chk(att_hdb, 8'h8C);
    rst_n <= 1'b0;
    @(posedge clock);
    chk(in_ready, 1'b0);
    chk(att_hdb, 8'h00);
    chk(active, 1'b0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk(in_ready, 1'b1);
    $display("test clock enable done");
  endtask
  // -------------------------------------------------------------
  // sequence and verdict
  // -------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_gate;
    t_duck;
    t_hold;
    t_env;
    t_exp;
    t_fifo;
    t_ce;
    close_out;
  end
  initial begin
    #3000000;
    err_total++;
    close_out;
  end
endmodule
